//--- logic/mrc_top.sv
// Refresh controller with its bus unit and register block decode.
// ============================================================================
// Notes on behaviour
// [R1] Refresh reads are requested without software.
// [R2] Nine-bit counter spaces requests by programmed clocks.
// [R3] Twelve-bit row address drives lines a1-a12.
// [R4] Lines a13-a19 come from programmable base.
// [R5] Every cycle has 20-bit address, strobes, status.
// [R6] Cycles last four clocks when ready is ignored, five or more when ended by ready.
// [R7] Hold request releases bus, grant answers, regain.
// [R8] Register block relocatable, memory or I/O space.
// [R9] Refresh keeps running during idle power mode.
// [R10] Refresh indicator low only during refresh cycles.
// [R11] Reset abandons any cycle and reinitialises.
// [R12] Cycle ends on ready unless chip-select ignores.
// [R13] Refresh waits cycle end; row increments after.
// [R14] Interval reloads; requests only while enabled.
`timescale 1ns/1ps
`default_nettype none
module mrc_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic idle_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_io,
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_io,
  input wire logic [19:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_done,
  output logic [19:0] addr_out,
  output logic bus_oe,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] status_n,
  output logic refresh_n,
  input wire logic ready,
  input wire logic cs_ready_ignore,
  input wire logic hold,
  output logic hlda
);

  // ==========================================================================
  // Register block decode
  function automatic logic block_hit(input logic [19:0] a, input logic io,
                                     input logic [15:0] reloc);
    block_hit = (a[19:8] == reloc[11:0]) &&
                (reloc[mrc_pkg::RELOC_MEM_BIT] == !io);
  endfunction

  logic [15:0] reloc_reg, reloc_next;
  logic [6:0] base_reg, base_next;
  logic [8:0] time_reg, time_next;
  logic en_reg, en_next;
  logic [11:0] row_reg, row_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic wr_hit, rd_hit;
  logic [7:0] wofs, rofs;
  logic [8:0] int_count;
  logic fire, pend_reg, pend_next;
  logic rdy_s, hold_s;
  logic rfsh_start, rfsh_done;

  assign wofs = reg_addr[7:0];
  assign rofs = reg_addr[7:0];
  assign wr_hit = reg_wr && block_hit(reg_addr, reg_io, reloc_reg); // see [R8]
  assign rd_hit = reg_rd && block_hit(reg_addr, reg_io, reloc_reg); // see [R8]

  // ==========================================================================
  // Registers
  always_comb begin
    reloc_next = reloc_reg;
    base_next = base_reg;
    time_next = time_reg;
    en_next = en_reg;
    row_next = row_reg;
    rdata_next = rdata_reg;
    rvalid_next = rd_hit;
    if (wr_hit) begin
      unique case (wofs)
        mrc_pkg::OFS_RELOC: reloc_next = reg_wdata; // see [R8]
        mrc_pkg::OFS_RBASE: base_next = reg_wdata[6:0]; // see [R4]
        mrc_pkg::OFS_RTIME: time_next = reg_wdata[8:0]; // see [R2]
        mrc_pkg::OFS_RCTRL: en_next = reg_wdata[mrc_pkg::CTRL_EN_BIT];
        mrc_pkg::OFS_RADDR: row_next = reg_wdata[12:1];
        default: ;
      endcase
    end
    // A finished refresh cycle outranks a software write to the row.
    if (rfsh_done) begin
      row_next = row_reg + mrc_pkg::ROW_STEP; // see [R13]
    end
    if (rd_hit) begin
      unique case (rofs)
        mrc_pkg::OFS_RELOC: rdata_next = reloc_reg;
        mrc_pkg::OFS_RBASE: rdata_next = {9'h000, base_reg};
        mrc_pkg::OFS_RTIME: rdata_next = {7'h00, time_reg};
        mrc_pkg::OFS_RCTRL: rdata_next = {en_reg, 6'h00, int_count};
        mrc_pkg::OFS_RADDR: rdata_next = {3'h0, row_reg, 1'b0};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reloc_reg <= mrc_pkg::RELOC_RST;
      base_reg <= mrc_pkg::RBASE_RST;
      time_reg <= mrc_pkg::RTIME_RST;
      en_reg <= mrc_pkg::RCTRL_EN_RST;
      row_reg <= mrc_pkg::RADDR_RST;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      reloc_reg <= reloc_next;
      base_reg <= base_next;
      time_reg <= time_next;
      en_reg <= en_next;
      row_reg <= row_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ==========================================================================
  // Refresh timing; idle_mode is deliberately not an input here.
  mrc_interval u_interval ( // see [R9]
    .clock(clock),
    .arst_n(arst_n),
    .enable(en_reg),
    .reload(wr_hit && wofs == mrc_pkg::OFS_RTIME),
    .interval(time_reg),
    .fire(fire),
    .count(int_count)
  );

  mrc_sync u_ready_sync (
    .clock(clock),
    .arst_n(arst_n),
    .pin(ready),
    .level(rdy_s)
  );

  mrc_sync u_hold_sync (
    .clock(clock),
    .arst_n(arst_n),
    .pin(hold),
    .level(hold_s)
  );

  // Set wins over the clear taken when the refresh cycle starts.
  always_comb begin
    pend_next = fire || (pend_reg && !rfsh_start); // see [R1]
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ==========================================================================
  // Bus unit
  mrc_pkg::mrc_bus_e state_reg, state_next;
  logic rfsh_reg, rfsh_next;
  logic we_reg, we_next;
  logic [19:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] cdata_reg, cdata_next;
  logic [2:0] st_reg, st_next;
  logic [2:0] len_reg, len_next;
  logic in_cycle, strobe;

  always_comb begin
    state_next = state_reg;
    rfsh_next = rfsh_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    cdata_next = cdata_reg;
    st_next = st_reg;
    rfsh_start = 1'b0;
    unique case (state_reg)
      mrc_pkg::BUS_IDLE: begin
        if (hold_s) begin
          state_next = mrc_pkg::BUS_HOLD; // see [R7]
        end else if (pend_reg) begin
          state_next = mrc_pkg::BUS_T1; // see [R13]
          rfsh_start = 1'b1;
          rfsh_next = 1'b1;
          we_next = 1'b0;
          addr_next = {base_reg, row_reg, 1'b0}; // see [R3] see [R4]
          st_next = mrc_pkg::ST_RD_MEM; // see [R1]
        end else if (cpu_req && !idle_mode) begin
          state_next = mrc_pkg::BUS_T1;
          rfsh_next = 1'b0;
          we_next = cpu_we;
          addr_next = cpu_addr; // see [R5]
          wdata_next = cpu_wdata;
          if (cpu_io) begin
            st_next = cpu_we ? mrc_pkg::ST_WR_IO : mrc_pkg::ST_RD_IO;
          end else begin
            st_next = cpu_we ? mrc_pkg::ST_WR_MEM : mrc_pkg::ST_RD_MEM;
          end
        end
      end
      mrc_pkg::BUS_T1: state_next = mrc_pkg::BUS_T2; // see [R6]
      mrc_pkg::BUS_T2: state_next = mrc_pkg::BUS_T3;
      mrc_pkg::BUS_T3: begin
        // Synced ready may be stale on the first T3 clock; wait one more.
        if ((rdy_s &&
             len_reg >= mrc_pkg::MIN_CYCLE_CLKS - mrc_pkg::LEN_STEP) ||
            cs_ready_ignore) begin
          state_next = mrc_pkg::BUS_T4; // see [R12]
          cdata_next = (we_reg || rfsh_reg) ? cdata_reg : data_in;
        end
      end
      mrc_pkg::BUS_T4: begin
        state_next = mrc_pkg::BUS_IDLE;
        st_next = mrc_pkg::ST_IDLE;
      end
      mrc_pkg::BUS_HOLD: begin
        if (!hold_s) begin
          state_next = mrc_pkg::BUS_IDLE; // see [R7]
        end
      end
    endcase
  end

  assign in_cycle = state_reg == mrc_pkg::BUS_T1 ||
                    state_reg == mrc_pkg::BUS_T2 ||
                    state_reg == mrc_pkg::BUS_T3 ||
                    state_reg == mrc_pkg::BUS_T4;
  assign strobe = state_reg == mrc_pkg::BUS_T2 ||
                  state_reg == mrc_pkg::BUS_T3;
  assign len_next = !in_cycle ? 3'h0 :
                    (&len_reg) ? len_reg : len_reg + mrc_pkg::LEN_STEP;
  assign rfsh_done = state_reg == mrc_pkg::BUS_T4 && rfsh_reg;

  // Reset drops any cycle in flight at once, refresh included.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= mrc_pkg::BUS_IDLE; // see [R11]
      rfsh_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      cdata_reg <= 16'h0000;
      st_reg <= mrc_pkg::ST_IDLE;
      len_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      rfsh_reg <= rfsh_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      cdata_reg <= cdata_next;
      st_reg <= st_next;
      len_reg <= len_next;
    end
  end

  assign addr_out = addr_reg;
  assign status_n = st_reg; // see [R5]
  assign bus_oe = state_reg != mrc_pkg::BUS_HOLD; // see [R7]
  assign hlda = state_reg == mrc_pkg::BUS_HOLD;
  assign rd_n = !(strobe && !we_reg);
  assign wr_n = !(strobe && we_reg);
  assign data_out = wdata_reg;
  assign data_oe = we_reg && in_cycle && state_reg != mrc_pkg::BUS_T1;
  assign refresh_n = !(in_cycle && rfsh_reg); // see [R10]
  assign cpu_done = state_reg == mrc_pkg::BUS_T4 && !rfsh_reg;
  assign cpu_rdata = cdata_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_RFSH_IND: assert property ( // see [R10]
    !refresh_n |-> (in_cycle && rfsh_reg && status_n == mrc_pkg::ST_RD_MEM))
    else $error("refresh indicator outside refresh cycle");

  AST_MIN_LEN: assert property ( // see [R6]
    (state_reg == mrc_pkg::BUS_T4) |-> (len_reg >= 3'h3))
    else $error("bus cycle shorter than four clocks");

  AST_WAIT: assert property ( // see [R12]
    (state_reg == mrc_pkg::BUS_T3 && !rdy_s && !cs_ready_ignore) |=>
      (state_reg == mrc_pkg::BUS_T3 && !rd_n == !we_reg))
    else $error("cycle ended without ready");

  AST_ROW_INC: assert property ( // see [R13]
    rfsh_done |=> (row_reg == $past(row_reg) + mrc_pkg::ROW_STEP))
    else $error("refresh row did not advance");

  AST_RFSH_ADDR: assert property ( // see [R3]
    (!refresh_n) |-> (addr_out[12:1] == row_reg &&
                      addr_out[19:13] == base_reg)) // see [R4]
    else $error("refresh address wrong");

  AST_HOLD_REL: assert property ( // see [R7]
    hlda |-> (!bus_oe && !data_oe && rd_n && wr_n))
    else $error("bus driven while granted away");

  AST_HOLD_BACK: assert property ( // see [R7]
    (hlda && !hold_s) |=> (!hlda && bus_oe))
    else $error("bus not regained after hold dropped");

  AST_REQ_SERVED: assert property ( // see [R1]
    (pend_reg && state_reg == mrc_pkg::BUS_IDLE && !hold_s) |=>
      !refresh_n)
    else $error("pending refresh not started");

  AST_IDLE_STATUS: assert property ( // see [R5]
    (state_reg == mrc_pkg::BUS_IDLE) |-> (status_n == mrc_pkg::ST_IDLE))
    else $error("status not idle between cycles");

  AST_REG_ANSWER: assert property ( // see [R8]
    rd_hit |=> reg_rvalid)
    else $error("register read not answered");

  AST_IDLE_RUN: assert property ( // see [R9]
    (idle_mode && fire && state_reg == mrc_pkg::BUS_IDLE && !hold_s)
      |-> ##[1:2] (!refresh_n || hlda))
    else $error("refresh stalled in idle mode");

  COV_REFRESH: cover property (rfsh_done);
  COV_WAIT: cover property (state_reg == mrc_pkg::BUS_T3 [*3]);
  COV_HOLD: cover property (hlda && pend_reg);
  COV_WRITE: cover property (cpu_done && we_reg);

endmodule
`default_nettype wire

//--- logic/mrc_pkg.sv
// Shared constants and types for the memory refresh controller.
`default_nettype none
package mrc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned INTERVAL_W = 9;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned BASE_W = 7;
  localparam int unsigned BLOCK_W = 12;

  // ==========================================================================
  // Register offsets inside the peripheral register block
  localparam logic [7:0] OFS_RELOC = 8'hA8;
  localparam logic [7:0] OFS_RBASE = 8'hB0;
  localparam logic [7:0] OFS_RTIME = 8'hB2;
  localparam logic [7:0] OFS_RCTRL = 8'hB4;
  localparam logic [7:0] OFS_RADDR = 8'hB6;

  // ==========================================================================
  // Field positions
  localparam int unsigned RELOC_MEM_BIT = 12;
  localparam int unsigned CTRL_EN_BIT = 15;
  localparam int unsigned ROW_LSB = 1;
  localparam int unsigned BASE_LSB = 13;
  localparam int unsigned BLOCK_LSB = 8;

  // ==========================================================================
  // Reset values and step constants
  localparam logic [15:0] RELOC_RST = 16'h00FF;
  localparam logic [6:0] RBASE_RST = 7'h00;
  localparam logic [8:0] RTIME_RST = 9'h000;
  localparam logic RCTRL_EN_RST = 1'b0;
  localparam logic [11:0] RADDR_RST = 12'h000;
  localparam logic [8:0] INTERVAL_ONE = 9'h001;
  localparam logic [11:0] ROW_STEP = 12'h001;
  localparam logic [2:0] LEN_STEP = 3'h1;

  // ==========================================================================
  // Bus cycle status codes, active-low lines s2..s0
  localparam logic [2:0] ST_RD_IO = 3'h1;
  localparam logic [2:0] ST_WR_IO = 3'h2;
  localparam logic [2:0] ST_RD_MEM = 3'h5;
  localparam logic [2:0] ST_WR_MEM = 3'h6;
  localparam logic [2:0] ST_IDLE = 3'h7;

  localparam logic [2:0] MIN_CYCLE_CLKS = 3'h4;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_T1, BUS_T2, BUS_T3, BUS_T4, BUS_HOLD
  } mrc_bus_e;

endpackage
`default_nettype wire

//--- logic/mrc_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module mrc_sync (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pin,
  output logic level
);

  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  // ==========================================================================
  // Stage one is read only by stage two; the filter looks at two and three.
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule
`default_nettype wire

//--- logic/mrc_interval.sv
// Refresh interval down-counter.
`timescale 1ns/1ps
`default_nettype none
module mrc_interval (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic reload,
  input wire logic [8:0] interval,
  output logic fire,
  output logic [8:0] count
);

  logic [8:0] count_reg, count_next;
  logic fire_reg, fire_next;

  // ==========================================================================
  // A value of 0 or 1 requests on every clock.
  always_comb begin
    count_next = count_reg;
    fire_next = 1'b0;
    if (reload || !enable) begin
      count_next = interval;
    end else if (count_reg <= mrc_pkg::INTERVAL_ONE) begin
      count_next = interval; // see [R14]
      fire_next = 1'b1; // see [R2]
    end else begin
      count_next = count_reg - mrc_pkg::INTERVAL_ONE; // see [R2]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= mrc_pkg::RTIME_RST;
      fire_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      fire_reg <= fire_next;
    end
  end

  assign fire = fire_reg;
  assign count = count_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_RELOAD: assert property ( // see [R2]
    (enable && !reload && count_reg <= mrc_pkg::INTERVAL_ONE) |=>
      (fire && count_reg == $past(interval)))
    else $error("interval counter did not fire and reload");

  AST_EN_ONLY: assert property ( // see [R14]
    !$past(enable) |-> !fire)
    else $error("refresh request while disabled");

endmodule
`default_nettype wire

//--- bench/mrc_mem_model.sv
// Local-bus memory partner that answers reads and returns ready.
`timescale 1ns/1ps
`default_nettype none
module mrc_mem_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [19:0] addr_out,
  input wire logic [4:0] wait_clks,
  output logic ready,
  output logic [15:0] data_in
);
  logic [4:0] cnt_reg;
  logic [15:0] last_reg;

  // ==========================================================================
  // Ready
  // A slow part holds ready low for a set number of clocks after the strobe
  // falls; the limit of 31 lets a scenario withhold ready for a whole cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 5'h00;
      ready <= 1'b0;
    end else if (!rd_n || !wr_n) begin
      if (cnt_reg >= wait_clks) begin
        ready <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end else begin
      cnt_reg <= 5'h00;
      ready <= 1'b0;
    end
  end

  // ==========================================================================
  // Data
  // Released lines show the inverse of the last word, so stale data never
  // passes for a fresh read.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 16'h0000;
    end else if (!rd_n) begin
      last_reg <= data_in;
    end
  end

  assign data_in = rd_n ? ~last_reg : (addr_out[16:1] ^ 16'h5A3C);
endmodule
`default_nettype wire

//--- bench/memory_refresh_controller_tb.sv
// Self-checking testbench for the memory refresh controller.
`timescale 1ns/1ps
`default_nettype none
module memory_refresh_controller_tb;
  logic clock = 1'b0, arst_n = 1'b0, idle_mode = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, reg_io = 1'b1, cpu_req = 1'b0, cpu_we = 1'b0;
  logic cpu_io = 1'b0, cs_ready_ignore = 1'b0, hold = 1'b0, sp = 1'b1;
  logic [19:0] reg_addr = 20'h00000, cpu_addr = 20'h00000, ra;
  logic [19:0] addr_out, pb = 20'h0FF00;
  logic [15:0] reg_wdata = 16'h0000, cpu_wdata = 16'h0000, d;
  logic [15:0] reg_rdata, cpu_rdata, data_in, data_out;
  logic reg_rvalid, cpu_done, bus_oe, data_oe, rd_n, wr_n, refresh_n;
  logic ready, hlda, v;
  logic [1:0] sb;
  logic [2:0] status_n, st;
  logic [4:0] wait_clks = 5'h02;
  logic [7:0] offs [4] = '{8'hB0, 8'hB2, 8'hB6, 8'hBA};
  int fails = 0, checks = 0, cyc = 0, t, t0, n, k;

  mrc_top i_mrc_top (.clock, .arst_n, .idle_mode, .reg_wr, .reg_rd,
    .reg_io, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .cpu_req,
    .cpu_we, .cpu_io, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_done,
    .addr_out, .bus_oe, .data_in, .data_out, .data_oe, .rd_n, .wr_n,
    .status_n, .refresh_n, .ready, .cs_ready_ignore, .hold, .hlda);

  mrc_mem_model i_mrc_mem_model (.clock, .arst_n, .rd_n, .wr_n,
    .addr_out, .wait_clks, .ready, .data_in);

  initial begin
    forever #50 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // ==========================================================================
  // Tasks
  task automatic wrap_up;
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] o);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_io = sp;
    reg_addr = pb | {12'h000, o};
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] o, input logic [15:0] w);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_io = sp;
    reg_addr = pb | {12'h000, o};
    reg_wdata = w;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic wait_fall;
    k = 0;
    while (refresh_n !== 1'b0) begin
      @(negedge clock);
      k++;
      if (k > 200) begin
        fails++;
        wrap_up;
      end
    end
    t = cyc;
    ra = addr_out;
    st = status_n;
  endtask

  // Returns at the first falling edge after the refresh cycle has ended.
  task automatic wait_rf;
    wait_fall;
    n = 0;
    while (refresh_n === 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) begin
      fails++;
      wrap_up;
    end
  endtask

  task automatic wait_hlda(input logic lvl);
    k = 0;
    while (hlda !== lvl) begin
      @(negedge clock);
      k++;
      if (k > 50) begin
        fails++;
        wrap_up;
      end
    end
  endtask

  task automatic cpu(input logic we, input logic io, input logic [2:0] es);
    @(negedge clock);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_io = io;
    cpu_addr = 20'h12344;
    cpu_wdata = 16'hC3A5;
    k = 0;
    sb = 2'b11;
    while (cpu_done !== 1'b1) begin
      @(negedge clock);
      k++;
      if ((rd_n & wr_n) !== 1'b1) begin
        sb = {wr_n, rd_n};
      end
      if (k > 100) begin
        fails++;
        wrap_up;
      end
    end
    cpu_req = 1'b0;
    chk("cycle_len", 20'h00001, 20'(k >= 4));
    chk("status", 20'(es), 20'(status_n));
    chk("addr", 20'h12344, addr_out);
    chk("strobes", we ? 20'h00001 : 20'h00002, 20'(sb));
    chk("data_oe", 20'(we), 20'(data_oe));
    if (we) begin
      chk("wdata", 20'h0C3A5, 20'(data_out));
    end else begin
      chk("rdata", 20'h0CB9E, 20'(cpu_rdata));
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(negedge clock);
    chk("refresh_n", 20'h00001, 20'(refresh_n));
    chk("status_n", 20'(mrc_pkg::ST_IDLE), 20'(status_n));
    chk("hlda", 20'h00000, 20'(hlda));
    arst_n = 1'b1;
    rd(mrc_pkg::OFS_RELOC);
    chk("location", 20'(mrc_pkg::RELOC_RST), 20'(d));
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("valid", 20'h00001, 20'(v));
      chk("reset_value", 20'h00000, 20'(d));
    end
    sp = 1'b0;
    rd(mrc_pkg::OFS_RBASE);
    chk("wrong_space", 20'h00000, 20'(v));
    sp = 1'b1;
    wr(mrc_pkg::OFS_RELOC, 16'h1020);
    pb = 20'h02000;
    sp = 1'b0;
    rd(mrc_pkg::OFS_RELOC);
    chk("moved", 20'h11020, {3'h0, v, d});
    wr(mrc_pkg::OFS_RBASE, 16'h0005);
    wr(mrc_pkg::OFS_RADDR, 16'h0246);
    wr(mrc_pkg::OFS_RTIME, 16'h0014);
    wr(mrc_pkg::OFS_RCTRL, 16'h8000);
    wait_rf;
    t0 = t;
    chk("rf_addr", 20'h0A246, ra);
    chk("rf_status", 20'(mrc_pkg::ST_RD_MEM), 20'(st));
    chk("rf_min", 20'h00001, 20'(n >= 4));
    wait_rf;
    chk("rf_spacing", 20'h00014, 20'(t - t0));
    chk("rf_next_row", 20'h0A248, ra);
    rd(mrc_pkg::OFS_RADDR);
    chk("row", 20'h0024A, 20'(d));
    idle_mode = 1'b1;
    wait_rf;
    chk("idle_rf", 20'h0A24A, ra);
    idle_mode = 1'b0;
    wait_clks = 5'h0A;
    wait_rf;
    chk("stretched", 20'h00001, 20'(n > 10));
    wait_clks = 5'h1F;
    cs_ready_ignore = 1'b1;
    wait_rf;
    chk("ignore_ready", 20'h00004, 20'(n));
    cs_ready_ignore = 1'b0;
    wait_clks = 5'h02;
    wr(mrc_pkg::OFS_RCTRL, 16'h0000);
    k = 0;
    repeat (60) begin
      @(negedge clock);
      k += int'(refresh_n === 1'b0);
    end
    chk("disabled", 20'h00000, 20'(k));
    cpu(1'b0, 1'b0, mrc_pkg::ST_RD_MEM);
    cpu(1'b1, 1'b0, mrc_pkg::ST_WR_MEM);
    cpu(1'b0, 1'b1, mrc_pkg::ST_RD_IO);
    cpu(1'b1, 1'b1, mrc_pkg::ST_WR_IO);
    wr(mrc_pkg::OFS_RCTRL, 16'h8000);
    hold = 1'b1;
    wait_hlda(1'b1);
    chk("released", 20'h00000, 20'(bus_oe));
    n = 0;
    repeat (40) begin
      @(negedge clock);
      n += int'(refresh_n === 1'b0);
    end
    chk("held_no_rf", 20'h00000, 20'(n));
    hold = 1'b0;
    wait_hlda(1'b0);
    wait_rf;
    chk("after_hold", 20'h00001, 20'(bus_oe));
    wait_fall;
    @(negedge clock);
    chk("rf_strobe", 20'h00000, 20'(rd_n));
    arst_n = 1'b0;
    #1;
    chk("abort_rf", 20'h00001, 20'(refresh_n));
    chk("abort_rd", 20'h00001, 20'(rd_n));
    @(negedge clock);
    arst_n = 1'b1;
    pb = 20'h0FF00;
    sp = 1'b1;
    rd(mrc_pkg::OFS_RELOC);
    chk("reinit", 20'(mrc_pkg::RELOC_RST), 20'(d));
    wrap_up;
  end
endmodule
`default_nettype wire
